// ### inc/flash_ctrl_pkg.sv
// Constants, types and field layout of the flash program/erase sequencer
// Notes on behaviour
// (R1) Start bit takes a write only when armed and right after the unlock pair.
// (R2) Start launches the selected operation; hardware clears it when done.
// (R3) Device reset clears only the arm bit of the control register.
// (R4) Arm at 1 allows start writes and enables the supply monitor.
// (R5) Failure flag is set when a sequence fails, cleared after a clean one.
// (R6) With monitor enabled, a low supply sets the sticky fault flag.
// (R7) Live dip status follows the monitor while the monitor is enabled.
// (R8) Operation select takes writes only while the arm bit is 0.
// (R9) Code 0001 programs one word at the target unless write-protected.
// (R10) Code 0011 programs one row at the target unless write-protected.
// (R11) Code 0100 erases the target page unless write-protected.
// (R12) Code 0101 erases the whole array only if no page is protected.
// (R13) Starting code 0000 clears failure and fault flags, changes no flash.
// (R14) Unimplemented control bits, upper sixteen included, read 0.
// (R15) No-operation and reserved codes leave flash alone; start still clears.
// (R16) Select or arm writes during an operation do not alter it.
package flash_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CONTROL = 5'h00;
	localparam logic [4:0] OFS_UNLOCK = 5'h04;
	localparam logic [4:0] OFS_TARGET = 5'h08;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int START_BIT = 15;
	localparam int ARM_BIT = 14;
	localparam int FAIL_BIT = 13;
	localparam int FAULT_BIT = 12;
	localparam int LIVE_BIT = 11;
	localparam int OP_LSB = 0;
	localparam int OP_W = 4;

	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_WORD = 4'h1;
	localparam logic [3:0] OP_ROW = 4'h3;
	localparam logic [3:0] OP_PAGE = 4'h4;
	localparam logic [3:0] OP_ARRAY = 4'h5;

	// ----------------------------------------------------------------
	// Unlock keys (values arbitrary) and unlock progress
	// ----------------------------------------------------------------
	localparam logic [31:0] UNLOCK_KEY_A = 32'h5A5A_0F0F;
	localparam logic [31:0] UNLOCK_KEY_B = 32'hA5A5_F0F0;
	localparam logic [1:0] UNL_NONE = 2'h0;
	localparam logic [1:0] UNL_HALF = 2'h1;
	localparam logic [1:0] UNL_READY = 2'h2;

	// ----------------------------------------------------------------
	// Interrupt status bits and reset values
	// ----------------------------------------------------------------
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_DIP = 2;
	localparam logic [3:0] OP_RST = 4'h0;
	localparam logic [31:0] TARGET_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT = 2'b11,
		ST_FINISH = 2'b10
	} seq_state_e;

	typedef struct packed {
		logic word_prog;
		logic row_prog;
		logic page_erase;
		logic array_erase;
		logic [31:0] location;
	} flash_cmd_s;

	typedef struct packed {
		logic done;
		logic error;
		logic loc_protected;
		logic any_protected;
	} flash_status_s;

endpackage

// ### verilog/bit_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
module bit_sync (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Level in and out
	input wire logic i_level,
	output logic o_level
);

	logic meta_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			o_level <= 1'b0;
		end else begin
			meta_q <= i_level;
			o_level <= meta_q;
		end
	end

endmodule

// ### verilog/sticky_irq.sv
// Sticky status bits with write-one-to-clear, mask and interrupt output
module sticky_irq #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Events and software access
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_wr,
	input wire logic [W-1:0] i_clr,
	input wire logic i_mask_wr,
	input wire logic [W-1:0] i_mask,
	// State
	output logic [W-1:0] o_status,
	output logic [W-1:0] o_mask,
	output logic o_irq
);

	logic [W-1:0] clr_bits;

	assign clr_bits = i_clr_wr ? i_clr : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_status <= '0;
		end else begin
			o_status <= (o_status & ~clr_bits) | i_set;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mask <= '0;
		end else if (i_mask_wr) begin
			o_mask <= i_mask;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(((o_status & ~clr_bits) | i_set) & o_mask);
		end
	end

endmodule

// ### verilog/flash_program_erase_control.sv
// Flash program/erase sequencer with its control register and bus slave
module flash_program_erase_control
	import flash_ctrl_pkg::*;
(
	// Clock and resets
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_por_resetn,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Flash array
	output flash_cmd_s o_flash_cmd,
	input wire flash_status_s i_flash_stat,
	// Supply monitor
	input wire logic i_supply_low,
	output logic o_supply_monitor_en,
	// Interrupt
	output logic o_irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic wait_q;
	logic req;
	logic wr;
	logic [31:0] rdata_d;
	logic [1:0] unl_q;
	logic start_q;
	logic arm_q;
	logic [3:0] op_q;
	logic fail_q;
	logic fault_q;
	logic live_q;
	logic [31:0] target_q;
	seq_state_e state_q;
	logic [3:0] run_op_q;
	logic [31:0] run_loc_q;
	logic result_q;
	logic dip_sync;
	logic start_wr_ok;
	logic ctrl_hi_wr;
	logic ctrl_lo_wr;
	logic changes;
	logic blocked;
	logic arm_rst_n;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle, then the transfer completes
	// ----------------------------------------------------------------
	assign req = i_avs_read | i_avs_write;
	assign wr = i_avs_write & ~wait_q;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (i_avs_address)
			OFS_CONTROL: begin
				rdata_d[START_BIT] = start_q; // R14
				rdata_d[ARM_BIT] = arm_q;
				rdata_d[FAIL_BIT] = fail_q;
				rdata_d[FAULT_BIT] = fault_q;
				rdata_d[LIVE_BIT] = live_q;
				rdata_d[OP_LSB +: OP_W] = op_q;
			end
			OFS_TARGET: rdata_d = target_q;
			OFS_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && wait_q) begin
			o_avs_readdata <= rdata_d;
		end
	end

	assign o_avs_waitrequest = wait_q;

	// ----------------------------------------------------------------
	// Unlock pair: key A then key B, consumed by the next write
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			unl_q <= UNL_NONE;
		end else if (wr) begin
			if (i_avs_address == OFS_UNLOCK && &i_avs_byteenable &&
				i_avs_writedata == UNLOCK_KEY_A) begin
				unl_q <= UNL_HALF;
			end else if (i_avs_address == OFS_UNLOCK &&
				&i_avs_byteenable && unl_q == UNL_HALF &&
				i_avs_writedata == UNLOCK_KEY_B) begin
				unl_q <= UNL_READY;
			end else begin
				unl_q <= UNL_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	assign ctrl_hi_wr = wr && i_avs_address == OFS_CONTROL &&
		i_avs_byteenable[1];
	assign ctrl_lo_wr = wr && i_avs_address == OFS_CONTROL &&
		i_avs_byteenable[0];
	assign start_wr_ok = ctrl_hi_wr && i_avs_writedata[START_BIT] &&
		arm_q && unl_q == UNL_READY && !start_q; // R1
	assign arm_rst_n = i_resetn & i_por_resetn;

	// Start: software sets, sequencer clears at the end
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			start_q <= 1'b0;
		end else if (state_q == ST_FINISH) begin
			start_q <= 1'b0; // R2
		end else if (start_wr_ok) begin
			start_q <= 1'b1; // R1
		end
	end

	// Arm is the only bit that a device reset touches
	always_ff @(posedge i_core_clk or negedge arm_rst_n) begin
		if (!arm_rst_n) begin
			arm_q <= 1'b0; // R3
		end else if (ctrl_hi_wr) begin
			arm_q <= i_avs_writedata[ARM_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			op_q <= OP_RST;
		end else if (ctrl_lo_wr && !arm_q) begin
			op_q <= i_avs_writedata[OP_LSB +: OP_W]; // R8
		end
	end

	// Target location, byte-writable
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			target_q <= TARGET_RST;
		end else if (wr && i_avs_address == OFS_TARGET) begin
			for (int b = 0; b < 4; b++) begin
				if (i_avs_byteenable[b]) begin
					target_q[8*b +: 8] <= i_avs_writedata[8*b +: 8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Supply monitor
	// ----------------------------------------------------------------
	bit_sync u_dip_sync (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_level(i_supply_low),
		.o_level(dip_sync)
	);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_supply_monitor_en <= 1'b0;
		end else begin
			o_supply_monitor_en <= arm_q; // R4
		end
	end

	// Live bit is not device-reset; disarm drops it via the monitor
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			live_q <= 1'b0; // R3
		end else begin
			live_q <= o_supply_monitor_en & dip_sync; // R7
		end
	end

	// Fault: a dip sets it, a started no-op clears it, set wins
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			fault_q <= 1'b0;
		end else if (o_supply_monitor_en && dip_sync) begin
			fault_q <= 1'b1; // R6
		end else if (state_q == ST_FINISH && run_op_q == OP_NONE) begin
			fault_q <= 1'b0; // R13
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		changes = 1'b0;
		blocked = 1'b0;
		case (op_q)
			OP_WORD, OP_ROW, OP_PAGE: begin
				changes = 1'b1; // R9 R10 R11
				blocked = i_flash_stat.loc_protected;
			end
			OP_ARRAY: begin
				changes = 1'b1;
				blocked = i_flash_stat.any_protected; // R12
			end
			default: begin
				changes = 1'b0; // R15
				blocked = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_q) begin
						state_q <= (changes && !blocked) ? ST_ISSUE :
							ST_FINISH; // R2 R15
					end
				end
				ST_ISSUE: state_q <= ST_WAIT;
				ST_WAIT: begin
					if (i_flash_stat.done) begin
						state_q <= ST_FINISH;
					end
				end
				ST_FINISH: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Operation copy held for the whole run
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			run_op_q <= OP_RST;
			run_loc_q <= TARGET_RST;
		end else if (state_q == ST_IDLE && start_q) begin
			run_op_q <= op_q; // R16
			run_loc_q <= target_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			result_q <= 1'b0;
		end else if (state_q == ST_IDLE && start_q) begin
			result_q <= changes & blocked;
		end else if (state_q == ST_WAIT && i_flash_stat.done) begin
			result_q <= i_flash_stat.error;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			fail_q <= 1'b0;
		end else if (state_q == ST_FINISH) begin
			fail_q <= result_q; // R5 R13
		end
	end

	// One-cycle command to the array
	always_ff @(posedge i_core_clk or negedge i_por_resetn) begin
		if (!i_por_resetn) begin
			o_flash_cmd <= '0;
		end else begin
			o_flash_cmd <= '0;
			o_flash_cmd.location <= run_loc_q;
			if (state_q == ST_ISSUE) begin
				o_flash_cmd.word_prog <= run_op_q == OP_WORD; // R9
				o_flash_cmd.row_prog <= run_op_q == OP_ROW; // R10
				o_flash_cmd.page_erase <= run_op_q == OP_PAGE; // R11
				o_flash_cmd.array_erase <= run_op_q == OP_ARRAY; // R12
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_set[IRQ_DONE] = state_q == ST_FINISH;
	assign irq_set[IRQ_FAIL] = state_q == ST_FINISH && result_q;
	assign irq_set[IRQ_DIP] = o_supply_monitor_en & dip_sync & ~live_q;

	sticky_irq #(
		.W(IRQ_W)
	) u_irq (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_set(irq_set),
		.i_clr_wr(wr && i_avs_address == OFS_IRQ_STATUS &&
			i_avs_byteenable[0]),
		.i_clr(i_avs_writedata[IRQ_W-1:0]),
		.i_mask_wr(wr && i_avs_address == OFS_IRQ_MASK &&
			i_avs_byteenable[0]),
		.i_mask(i_avs_writedata[IRQ_W-1:0]),
		.o_status(irq_status),
		.o_mask(irq_mask),
		.o_irq(o_irq)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_start_unlock_gate: assert property ( // R1
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		$rose(start_q) |-> $past(arm_q) && $past(unl_q) == UNL_READY)
		else $error("start set without arm and unlock");

	a_start_clears: assert property ( // R2
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(state_q == ST_WAIT && i_flash_stat.done) |=> ##1 !start_q)
		else $error("start not cleared after completion");

	a_cmd_needs_start: assert property ( // R2
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(o_flash_cmd.word_prog || o_flash_cmd.row_prog ||
		o_flash_cmd.page_erase || o_flash_cmd.array_erase) |->
		start_q && state_q == ST_WAIT)
		else $error("flash command without running operation");

	a_monitor_off: assert property ( // R4
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(!arm_q)[*2] |-> !o_supply_monitor_en ##1 !live_q)
		else $error("monitor active while disarmed");

	a_fault_sets: assert property ( // R6
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(o_supply_monitor_en && dip_sync) |=> fault_q)
		else $error("fault flag missed a dip");

	a_live_follows: assert property ( // R7
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		live_q |-> $past(o_supply_monitor_en) && $past(dip_sync))
		else $error("live status without enabled dip");

	a_op_locked: assert property ( // R8
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		$past(arm_q) |-> $stable(op_q))
		else $error("operation select changed while armed");

	a_blocked_fails: assert property ( // R5
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(state_q == ST_IDLE && start_q && changes && blocked) |=>
		state_q == ST_FINISH ##1 (fail_q && !start_q))
		else $error("protected operation did not fail");

	a_noop_skips: assert property ( // R15
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(state_q == ST_IDLE && start_q && !changes) |=>
		state_q == ST_FINISH ##1 (!start_q && !fail_q))
		else $error("no-op code did not finish cleanly");

	a_clear_flags: assert property ( // R13
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(state_q == ST_FINISH && run_op_q == OP_NONE && !dip_sync) |=>
		!fail_q && !fault_q)
		else $error("flags not cleared by code 0000");

	a_reserved_zero: assert property ( // R14
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(i_avs_read && wait_q && i_avs_address == OFS_CONTROL) |=>
		o_avs_readdata[31:16] == 16'h0000 &&
		o_avs_readdata[10:4] == 7'h00)
		else $error("unimplemented control bits read nonzero");

	a_run_held: assert property ( // R16
		@(posedge i_core_clk) disable iff (!i_resetn || !i_por_resetn)
		(state_q != ST_IDLE && $past(state_q) != ST_IDLE) |->
		$stable(run_op_q) && $stable(run_loc_q))
		else $error("running operation changed mid-run");

endmodule

// ### verification/flash_array_model.sv
// Behavioural flash array answering the sequencer's command pulses
module flash_array_model
	import flash_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Command and status
	input wire flash_cmd_s i_cmd,
	output flash_status_s o_stat,
	// Test controls
	input wire logic i_slow,
	input wire logic i_fail,
	input wire logic i_prot,
	// Observed work
	output logic [7:0] o_count,
	output logic [3:0] o_kind,
	output logic [31:0] o_loc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wait_q;
	logic busy_q;
	logic done_w;
	logic [3:0] kind_w;
	assign kind_w = {i_cmd.word_prog, i_cmd.row_prog, i_cmd.page_erase,
		i_cmd.array_erase};
	assign done_w = busy_q && (wait_q == 8'h01);
	// Error only means something with done; otherwise it wobbles
	assign o_stat = {done_w, done_w ? i_fail : wait_q[0], i_prot, i_prot};
	// ----------------------------------------------------------------
	// Record each command and answer after a short or long delay
	// ----------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_q <= 1'b0;
			wait_q <= 8'h00;
			o_count <= 8'h00;
			o_kind <= 4'h0;
			o_loc <= 32'h0000_0000;
		end else if (kind_w != 4'h0) begin
			busy_q <= 1'b1;
			wait_q <= i_slow ? 8'h14 : 8'h01;
			o_count <= o_count + 8'h01;
			o_kind <= kind_w;
			o_loc <= i_cmd.location;
		end else if (busy_q) begin
			wait_q <= wait_q - 8'h01;
			busy_q <= (wait_q != 8'h01);
		end
	end
endmodule

// ### verification/tb.sv
// Self-checking bench of the flash program/erase sequencer
module tb
	import flash_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, resetn, por_resetn, avs_read, avs_write;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, supply_low, monitor_en, irq, slow, ffail, prot;
	flash_cmd_s flash_cmd;
	flash_status_s flash_stat;
	logic [7:0] count;
	logic [3:0] kind;
	logic [31:0] loc, q;
	int err_count = 0;
	int checks_done = 0;

	flash_program_erase_control dut_u (.i_core_clk(core_clk),
		.i_resetn(resetn), .i_por_resetn(por_resetn),
		.i_avs_address(avs_address), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest), .o_flash_cmd(flash_cmd),
		.i_flash_stat(flash_stat), .i_supply_low(supply_low),
		.o_supply_monitor_en(monitor_en), .o_irq(irq));
	flash_array_model flash_u (.i_core_clk(core_clk),
		.i_resetn(por_resetn), .i_cmd(flash_cmd), .o_stat(flash_stat),
		.i_slow(slow), .i_fail(ffail), .i_prot(prot), .o_count(count),
		.o_kind(kind), .o_loc(loc));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task summarize;
		if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			chk("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
			summarize();
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_map;
		rd(OFS_CONTROL);
		chk("control at reset", q, 32'h0000_0000);
		rd(5'h14);
		chk("unmapped", q, 32'h0000_0000);
		wr(OFS_CONTROL, 32'hFFFF_07F5);
		rd(OFS_CONTROL);
		chk("unimplemented bits", q, 32'h0000_0005);
		wr(OFS_CONTROL, 32'h0000_8005);
		rd(OFS_CONTROL);
		chk("start while disarmed", q, 32'h0000_0005);
		avs_byteenable <= 4'h2;
		wr(OFS_CONTROL, 32'h0000_000A);
		avs_byteenable <= 4'hF;
		rd(OFS_CONTROL);
		chk("lane gating", q, 32'h0000_0005);
		chk("monitor off", {31'h0, monitor_en}, 32'h0);
	endtask
	task t_lock;
		logic [7:0] c0;
		c0 = count;
		wr(OFS_CONTROL, 32'h0000_4005);
		wr(OFS_CONTROL, 32'h0000_C005);
		rd(OFS_CONTROL);
		chk("start without unlock", q, 32'h0000_4005);
		chk("monitor on", {31'h0, monitor_en}, 32'h1);
		wr(OFS_CONTROL, 32'h0000_4003);
		rd(OFS_CONTROL);
		chk("select while armed", q, 32'h0000_4005);
		wr(OFS_UNLOCK, UNLOCK_KEY_A);
		wr(OFS_UNLOCK, UNLOCK_KEY_B);
		wr(OFS_TARGET, 32'h0000_0100);
		wr(OFS_CONTROL, 32'h0000_C005);
		rd(OFS_CONTROL);
		chk("broken unlock", q, 32'h0000_4005);
		chk("no command", {24'h0, count - c0}, 32'h0);
	endtask
	task run_op(input logic [3:0] op, input logic s, input logic p,
		input logic f, input logic poke);
		logic real_op, hit, expf;
		logic [7:0] c0;
		logic [3:0] ek;
		int n;
		real_op = (op == OP_WORD || op == OP_ROW || op == OP_PAGE ||
			op == OP_ARRAY);
		hit = real_op && !p;
		expf = real_op && (p || f);
		ek = (op == OP_WORD) ? 4'h8 : (op == OP_ROW) ? 4'h4 :
			(op == OP_PAGE) ? 4'h2 : 4'h1;
		slow <= s;
		prot <= p;
		ffail <= f;
		wr(OFS_TARGET, {28'h0012_340, op});
		wr(OFS_CONTROL, 32'h0000_0000);
		wr(OFS_CONTROL, {28'h0, op});
		wr(OFS_CONTROL, {28'h0000_400, op});
		wr(OFS_UNLOCK, UNLOCK_KEY_A);
		wr(OFS_UNLOCK, UNLOCK_KEY_B);
		c0 = count;
		wr(OFS_CONTROL, {28'h0000_C00, op});
		rd(OFS_CONTROL);
		if (hit && s) chk("start held", {31'h0, q[START_BIT]}, 32'h1);
		if (poke) wr(OFS_CONTROL, 32'h0000_0002);
		n = 0;
		while (q[START_BIT] !== 1'b0 && n < 40) begin
			rd(OFS_CONTROL);
			n++;
		end
		if (q[START_BIT] !== 1'b0) begin
			chk("start timeout", {31'h0, q[START_BIT]}, 32'h0);
			summarize();
		end
		chk("control after op", q & 32'h0000_E00F,
			{17'h0, !poke, expf, 9'h0, op});
		chk("command count", {24'h0, count - c0}, {31'h0, hit});
		if (hit) chk("command kind", {28'h0, kind}, {28'h0, ek});
		if (hit) chk("location", loc, {28'h0012_340, op});
	endtask
	task t_irq;
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		wr(OFS_IRQ_STATUS, 32'h0000_0007);
		rd(OFS_IRQ_STATUS);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		run_op(OP_WORD, 1'b0, 1'b0, 1'b0, 1'b0);
		rd(OFS_IRQ_STATUS);
		chk("done status", q & 32'h0000_0007, 32'h1);
		chk("irq raised", {31'h0, irq}, 32'h1);
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		rd(OFS_IRQ_STATUS);
		chk("irq masked", {31'h0, irq}, 32'h0);
	endtask
	task t_reset;
		run_op(OP_PAGE, 1'b0, 1'b0, 1'b1, 1'b0);
		rd(OFS_IRQ_STATUS);
		chk("fail status", q & 32'h0000_0002, 32'h2);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		rd(OFS_CONTROL);
		chk("device reset", q & 32'h0000_E00F, 32'h0000_2004);
		chk("monitor after reset", {31'h0, monitor_en}, 32'h0);
	endtask
	task t_supply;
		wr(OFS_CONTROL, 32'h0000_0000);
		supply_low <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(OFS_CONTROL);
		chk("dip disarmed", q & 32'h0000_1800, 32'h0);
		supply_low <= 1'b0;
		wr(OFS_CONTROL, 32'h0000_4000);
		supply_low <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(OFS_CONTROL);
		chk("dip armed", q & 32'h0000_1800, 32'h0000_1800);
		rd(OFS_IRQ_STATUS);
		chk("dip status", q & 32'h0000_0004, 32'h4);
		supply_low <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(OFS_CONTROL);
		chk("dip over", q & 32'h0000_1800, 32'h0000_1000);
		run_op(OP_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("fault cleared", q & 32'h0000_1000, 32'h0);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		por_resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		supply_low = 1'b0;
		slow = 1'b0;
		ffail = 1'b0;
		prot = 1'b0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		por_resetn <= 1'b1;
		t_map();
		t_lock();
		run_op(OP_PAGE, 1'b1, 1'b0, 1'b1, 1'b0);
		for (int k = 0; k < 16; k++) run_op(k[3:0], 1'b0, 1'b0, 1'b0, 1'b0);
		run_op(OP_WORD, 1'b0, 1'b1, 1'b0, 1'b0);
		run_op(OP_ARRAY, 1'b0, 1'b1, 1'b0, 1'b0);
		run_op(OP_ROW, 1'b1, 1'b0, 1'b0, 1'b1);
		t_supply();
		t_irq();
		t_reset();
		summarize();
	end
endmodule
